/* File: core/exec_datapath.sv */
// execute datapath for a 16-bit data, 24-bit instruction subset
// ----------------------------------------------------------------
// Notes on behaviour
// [RULE1] add and add-with-carry in one cycle, set C DC N OV Z
// [RULE2] AND in one cycle, updates only N and Z
// [RULE3] one-bit signed shift keeps sign, updates C N OV Z
// [RULE4] multi-bit signed shift by reg or literal, only N and Z
// [RULE5] short literal is five bits, zero to thirty-one
// [RULE6] cond branch 1 cycle not taken, 2 taken; others always 2
// [RULE7] flag-to-bit copies C or Z into selected bit, no flags
// [RULE8] test-and-skip 1 cycle, 2 or 3 when skipping, no flags
// [RULE9] bit ops pick the bit with a four-bit field
// [RULE10] file address limited to 0 through 1FFF
// [RULE11] medium literal 0-255 in byte mode, 0-1023 in word mode
// [RULE12] status holds C DC N OV Z; zero sticky where defined
// [RULE13] absolute program address has its lsb forced to zero
// [RULE14] sixteen working registers usable as any operand
// [RULE15] register zero is the file-op accumulator and alt dest
// [RULE16] word size unless byte or double-word selector given; SZ_DWORD is handled as word size here
// [RULE17] direct, indirect, pre/post modified and offset forms
// [RULE18] single-word instruction is 24 bits, top 8 the opcode
// [RULE19] second word of two-word insn executes as no-op
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.svh"
module exec_datapath #(
	parameter int DATA_W = `DATA_W,
	parameter int NREGS  = `NREGS
) (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rstn_i,
	// decoded instruction
	input  wire logic                     insn_valid_i,
	input  wire logic [`INSN_W-1:0]       insn_word_i,
	input  wire exec_pkg::op_t            op_i,
	input  wire exec_pkg::cond_t          cond_i,
	input  wire exec_pkg::src_t           src_sel_i,
	input  wire exec_pkg::amode_t         src_mode_i,
	input  wire exec_pkg::amode_t         dst_mode_i,
	input  wire exec_pkg::size_t_t        size_i,
	input  wire logic [3:0]               base_operand_reg_i,
	input  wire logic [3:0]               source_operand_reg_i,
	input  wire logic [3:0]               destination_operand_reg_i,
	input  wire logic                     dest_is_file_i,
	input  wire logic                     sticky_zero_i,
	input  wire logic [`SHORT_IMM_W-1:0]  short_immediate_i,
	input  wire logic [`MED_IMM_W-1:0]    medium_immediate_i,
	input  wire logic [`BITPOS_W-1:0]     bit_position_field_i,
	input  wire logic [`FILE_ADDR_W-1:0]  file_addr_i,
	input  wire logic [`PADDR_W-1:0]      abs_target_i,
	input  wire logic                     next_is_two_word_i,
	// data memory
	output logic [`FILE_ADDR_W-1:0]       mem_addr_o,
	output logic                          mem_we_o,
	output logic [DATA_W-1:0]             mem_wdata_o,
	input  wire logic [DATA_W-1:0]        mem_rdata_i,
	// program flow
	output logic                          insn_ready_o,
	output logic                          pc_load_o,
	output logic [`PADDR_W-1:0]           pc_target_o,
	output logic                          flush_o,
	// status
	output logic [`SR_W-1:0]              status_o
);
	import exec_pkg::*;
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [DATA_W-1:0]      regs_r [NREGS];
	logic [DATA_W-1:0]      regs_nxt [NREGS];
	logic [`SR_W-1:0]       sr_r, sr_nxt;
	state_t                 st_r, st_nxt;
	logic                   pcl_r, pcl_nxt, mwe_r, mwe_nxt;
	logic [`PADDR_W-1:0]    pct_r, pct_nxt;
	logic [`FILE_ADDR_W-1:0] maddr_r, maddr_nxt;
	logic [DATA_W-1:0]      mwd_r, mwd_nxt;
	// ------------------------------------------------------------
	// operand fetch and addressing
	// ------------------------------------------------------------
	logic                   is_second_word, is_byte;
	logic [DATA_W-1:0]      wb_val, ws_val, opa, opb, acc;
	logic [DATA_W-1:0]      eff_src, eff_dst, med_val, step;
	logic [`FILE_ADDR_W-1:0] faddr;
	assign is_second_word =
		insn_word_i[`INSN_W-1 -: `OPC_W] == `OPC_W'h00; // [RULE18] [RULE19]
	assign is_byte = (size_i == SZ_BYTE); // [RULE16]
	assign acc    = regs_r[0]; // [RULE15]
	assign wb_val = regs_r[base_operand_reg_i]; // [RULE14]
	assign ws_val = regs_r[source_operand_reg_i];
	assign faddr  = file_addr_i & `FILE_ADDR_MAX; // [RULE10]
	assign med_val = is_byte
		? {{(DATA_W-8){1'b0}}, medium_immediate_i[7:0]} // [RULE11]
		: {{(DATA_W-`MED_IMM_W){1'b0}}, medium_immediate_i};
	function automatic logic [DATA_W-1:0] ind_addr(
		input amode_t m, input logic [DATA_W-1:0] r,
		input logic [DATA_W-1:0] ofs, input logic [DATA_W-1:0] step);
		case (m)
			AM_PREINC: ind_addr = r + step;
			AM_PREDEC: ind_addr = r - step;
			AM_OFFSET: ind_addr = r + ofs;
			default:   ind_addr = r;
		endcase
	endfunction
	assign step = is_byte ? 16'h0001 : 16'h0002;
	assign eff_src = ind_addr(src_mode_i, ws_val, wb_val, step); // [RULE17]
	assign eff_dst = ind_addr(dst_mode_i,
		regs_r[destination_operand_reg_i], wb_val, step);
	always_comb
	begin
		opb = '0;
		case (src_sel_i)
			SRC_FILE:  opb = mem_rdata_i;
			SRC_SHORT: opb = {{(DATA_W-`SHORT_IMM_W){1'b0}},
				short_immediate_i}; // [RULE5]
			SRC_MED:   opb = med_val;
			default:   opb = (src_mode_i == AM_DIRECT) ? ws_val
				: mem_rdata_i;
		endcase
		opa = (src_sel_i == SRC_FILE) ? acc
			: (src_sel_i == SRC_MED) ? regs_r[destination_operand_reg_i]
			: wb_val;
	end

	// ------------------------------------------------------------
	// alu
	// ------------------------------------------------------------
	logic [DATA_W:0]   sum;
	logic [4:0]        half;
	logic [DATA_W-1:0] res, shval, bitmask;
	logic              cin, msb, ovf, cres, hres, res_zero;
	logic [4:0]        shamt;
	assign cin  = (op_i == OP_ADD_WITH_CARRY_OP) ? sr_r[`SR_C] : 1'b0;
	assign sum  = {1'b0, opa} + {1'b0, opb} + {{DATA_W{1'b0}}, cin}; // [RULE1]
	assign half = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
	assign shval = (src_sel_i == SRC_FILE) ? mem_rdata_i : opb;
	assign shamt = (src_sel_i == SRC_SHORT) ? short_immediate_i // [RULE5]
		: {1'b0, ws_val[3:0]};
	assign bitmask = 16'h0001 << bit_position_field_i; // [RULE9]
	always_comb
	begin
		res  = '0;
		msb  = 1'b0;
		ovf  = 1'b0;
		cres = 1'b0;
		hres = 1'b0;
		case (op_i)
			OP_ADD, OP_ADD_WITH_CARRY_OP:
			begin
				res  = sum[DATA_W-1:0];
				msb  = is_byte ? sum[7] : sum[DATA_W-1];
				cres = is_byte ? (opa[7:0] + opb[7:0] + 9'(cin)) > 9'h0FF
					: sum[DATA_W];
				hres = half[4];
				ovf  = is_byte
					? (opa[7] == opb[7]) && (sum[7] != opa[7])
					: (opa[DATA_W-1] == opb[DATA_W-1])
						&& (sum[DATA_W-1] != opa[DATA_W-1]);
			end
			OP_AND:
			begin
				res = opa & opb; // [RULE2]
				msb = is_byte ? res[7] : res[DATA_W-1];
			end
			OP_ASR1:
			begin
				res  = {shval[DATA_W-1], shval[DATA_W-1:1]}; // [RULE3]
				msb  = res[DATA_W-1];
				cres = shval[0];
			end
			OP_ASRN:
			begin
				res = DATA_W'($signed(wb_val) >>> shamt); // [RULE4]
				msb = res[DATA_W-1];
			end
			default: res = '0;
		endcase
	end
	assign res_zero = is_byte ? (res[7:0] == 8'h00) : (res == '0);
	logic cc_true, fc, fz, fn, fv;
	assign {fn, fv, fz, fc} =
		{sr_r[`SR_N], sr_r[`SR_OV], sr_r[`SR_Z], sr_r[`SR_C]};
	always_comb
	begin
		case (cond_i)
			CC_C:    cc_true = fc;
			CC_NC:   cc_true = !fc;
			CC_Z:    cc_true = fz;
			CC_NZ:   cc_true = !fz;
			CC_N:    cc_true = fn;
			CC_NN:   cc_true = !fn;
			CC_OV:   cc_true = fv;
			CC_NOV:  cc_true = !fv;
			CC_GE:   cc_true = (fn == fv);
			CC_GT:   cc_true = !fz && (fn == fv);
			CC_LE:   cc_true = fz || (fn != fv);
			CC_LT:   cc_true = (fn != fv);
			CC_GEU:  cc_true = fc;
			CC_GTU:  cc_true = fc && !fz;
			CC_LEU:  cc_true = !fc || fz;
			CC_LTU:  cc_true = !fc;
			default: cc_true = 1'b0;
		endcase
	end
	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic              go, tbit, wr_res;
	logic [DATA_W-1:0] bsrc, bres;
	assign go = insn_valid_i && (st_r == ST_EXEC) && !is_second_word;
	assign bsrc = (src_sel_i == SRC_FILE) ? mem_rdata_i : ws_val;
	assign tbit = |(bsrc & bitmask);
	always_comb
	begin
		regs_nxt  = regs_r;
		sr_nxt    = sr_r;
		st_nxt    = ST_EXEC;
		pcl_nxt   = 1'b0;
		pct_nxt   = pct_r;
		maddr_nxt = faddr;
		mwe_nxt   = 1'b0;
		mwd_nxt   = mwd_r;
		bres      = bsrc;
		wr_res    = 1'b0;
		case (st_r)
			ST_STALL2: st_nxt = ST_STALL1;
			ST_STALL1: st_nxt = ST_EXEC;
			default:
			begin
				if (go)
				begin
					case (op_i)
						OP_ADD, OP_ADD_WITH_CARRY_OP:
						begin
							wr_res = 1'b1;
							sr_nxt[`SR_C]  = cres; // [RULE1]
							sr_nxt[`SR_DC] = hres;
							sr_nxt[`SR_N]  = msb;
							sr_nxt[`SR_OV] = ovf;
							sr_nxt[`SR_Z]  = (sticky_zero_i && op_i == OP_ADD_WITH_CARRY_OP)
								? (sr_r[`SR_Z] && res_zero) : res_zero; // [RULE12]
						end
						OP_AND, OP_ASRN:
						begin
							wr_res = 1'b1;
							sr_nxt[`SR_N] = msb; // [RULE2] [RULE4]
							sr_nxt[`SR_Z] = res_zero;
						end
						OP_ASR1:
						begin
							wr_res = 1'b1;
							sr_nxt[`SR_C]  = cres; // [RULE3]
							sr_nxt[`SR_N]  = msb;
							sr_nxt[`SR_OV] = 1'b0;
							sr_nxt[`SR_Z]  = res_zero;
						end
						OP_BIT_CLEAR_OP, OP_BIT_SET_OP, OP_BTG, OP_BSWC, OP_BSWZ:
						begin
							case (op_i)
								OP_BIT_CLEAR_OP: bres = bsrc & ~bitmask;
								OP_BIT_SET_OP: bres = bsrc | bitmask;
								OP_BTG:  bres = bsrc ^ bitmask;
								OP_BSWC: bres = ws_val[wb_val[3:0]] == fc
									? ws_val : ws_val ^ (16'h0001 << wb_val[3:0]); // [RULE7]
								default: bres = ws_val[wb_val[3:0]] == fz
									? ws_val : ws_val ^ (16'h0001 << wb_val[3:0]);
							endcase
							if (src_sel_i == SRC_FILE)
							begin
								mwe_nxt = 1'b1;
								mwd_nxt = bres;
							end
							else
								regs_nxt[source_operand_reg_i] = bres;
						end
						OP_TEST_SKIP_IF_CLEAR_OP, OP_BTSS:
						begin
							if (tbit == (op_i == OP_BTSS)) // [RULE8]
								st_nxt = next_is_two_word_i ? ST_STALL2
									: ST_STALL1;
						end
						OP_BRA, OP_BRAW:
						begin
							pcl_nxt = 1'b1; // [RULE6]
							pct_nxt = (op_i == OP_BRAW)
								? {7'h00, ws_val[DATA_W-1:1], 1'b0}
								: {abs_target_i[`PADDR_W-1:1], 1'b0}; // [RULE13]
							st_nxt  = ST_STALL1;
						end
						OP_BCOND:
						begin
							if (cc_true) // [RULE6]
							begin
								pcl_nxt = 1'b1;
								pct_nxt = {abs_target_i[`PADDR_W-1:1], 1'b0};
								st_nxt  = ST_STALL1;
							end
						end
						default: st_nxt = ST_EXEC;
					endcase
					if (wr_res)
					begin
						if (dest_is_file_i)
						begin
							mwe_nxt = 1'b1;
							mwd_nxt = res;
						end
						else if (src_sel_i == SRC_FILE)
							regs_nxt[0] = res; // [RULE15]
						else if (dst_mode_i == AM_DIRECT)
							regs_nxt[destination_operand_reg_i] = is_byte
								? {regs_r[destination_operand_reg_i][15:8],
									res[7:0]} : res;
						else
						begin
							mwe_nxt   = 1'b1; // [RULE17]
							mwd_nxt   = res;
							maddr_nxt = eff_dst[`FILE_ADDR_W-1:0];
						end
					end
					if (src_sel_i == SRC_REG && src_mode_i != AM_DIRECT
						&& src_mode_i != AM_IND && src_mode_i != AM_OFFSET)
						regs_nxt[source_operand_reg_i] =
							(src_mode_i == AM_POSTINC || src_mode_i == AM_PREINC)
							? ws_val + step : ws_val - step;
				end
			end
		endcase
	end
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			regs_r  <= '{default: '0};
			sr_r    <= `SR_RESET;
			st_r    <= ST_EXEC;
			pcl_r   <= 1'b0;
			pct_r   <= '0;
			maddr_r <= '0;
			mwe_r   <= 1'b0;
			mwd_r   <= '0;
		end
		else
		begin
			regs_r  <= regs_nxt;
			sr_r    <= sr_nxt;
			st_r    <= st_nxt;
			pcl_r   <= pcl_nxt;
			pct_r   <= pct_nxt;
			maddr_r <= maddr_nxt;
			mwe_r   <= mwe_nxt;
			mwd_r   <= mwd_nxt;
		end
	end

	assign insn_ready_o = (st_r == ST_EXEC);
	assign flush_o      = (st_r != ST_EXEC);
	assign pc_load_o    = pcl_r;
	assign pc_target_o  = pct_r;
	assign mem_addr_o   = mwe_r ? maddr_r : faddr;
	assign mem_we_o     = mwe_r;
	assign mem_wdata_o  = mwd_r;
	assign status_o     = sr_r;
endmodule
`default_nettype wire

/* File: core/exec_consts.svh */
// constants for the execute datapath subset
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH
`define INSN_W        24
`define OPC_W         8
`define DATA_W        16
`define NREGS         16
`define FILE_ADDR_W   13
`define FILE_ADDR_MAX 13'h1FFF
`define SHORT_IMM_W   5
`define MED_IMM_W     10
`define MED_IMM_BYTE_MAX 10'h0FF
`define BITPOS_W      4
`define PADDR_W       23
`define SR_C          0
`define SR_Z          1
`define SR_OV         2
`define SR_N          3
`define SR_DC         4
`define SR_W          5
`define SR_RESET      5'h00
`endif

/* File: core/exec_pkg.sv */
// types for the execute datapath subset
`default_nettype none
package exec_pkg;
	typedef enum logic [4:0] {
		OP_NOP, OP_ADD, OP_ADD_WITH_CARRY_OP, OP_AND, OP_ASR1, OP_ASRN,
		OP_BIT_CLEAR_OP, OP_BIT_SET_OP, OP_BTG, OP_BSWC, OP_BSWZ,
		OP_TEST_SKIP_IF_CLEAR_OP, OP_BTSS, OP_BRA, OP_BRAW, OP_BCOND
	} op_t;
	typedef enum logic [3:0] {
		CC_C, CC_NC, CC_Z, CC_NZ, CC_N, CC_NN, CC_OV, CC_NOV,
		CC_GE, CC_GT, CC_LE, CC_LT, CC_GEU, CC_GTU, CC_LEU, CC_LTU
	} cond_t;
	typedef enum logic [1:0] {
		SRC_REG, SRC_FILE, SRC_SHORT, SRC_MED
	} src_t;
	typedef enum logic [2:0] {
		AM_DIRECT, AM_IND, AM_POSTINC, AM_POSTDEC,
		AM_PREINC, AM_PREDEC, AM_OFFSET
	} amode_t;
	typedef enum logic [1:0] {
		SZ_WORD, SZ_BYTE, SZ_DWORD
	} size_t_t;
	typedef enum logic [1:0] {
		ST_EXEC, ST_STALL1, ST_STALL2
	} state_t;
endpackage
`default_nettype wire

/* File: verif/exec_datapath_checker.sv */
// checker for the execute datapath subset
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.svh"
module exec_datapath_checker
	import exec_pkg::*;
(
	// clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rstn_i,
	// instruction side
	input  wire logic                    insn_valid_i,
	input  wire logic [`INSN_W-1:0]      insn_word_i,
	input  wire exec_pkg::op_t           op_i,
	input  wire logic                    dest_is_file_i,
	input  wire exec_pkg::src_t          src_sel_i,
	input  wire logic [`FILE_ADDR_W-1:0] file_addr_i,
	// outputs watched
	input  wire logic [`FILE_ADDR_W-1:0] mem_addr_o,
	input  wire logic                    mem_we_o,
	input  wire logic                    insn_ready_o,
	input  wire logic                    pc_load_o,
	input  wire logic [`PADDR_W-1:0]     pc_target_o,
	input  wire logic                    flush_o,
	input  wire logic [`SR_W-1:0]        status_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic fire;
	assign fire = insn_valid_i && insn_ready_o && (insn_word_i[23:16] != 8'h00);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_flush_ready: assert property (flush_o == !insn_ready_o)
		else $error("flush not inverse of ready");
	a_pc_even: assert property (pc_load_o |-> !pc_target_o[0])
		else $error("odd branch target");
	a_branch_two: assert property (fire && op_i == OP_BRA
		|=> pc_load_o && !insn_ready_o ##1 insn_ready_o)
		else $error("branch not two cycles");
	a_and_keeps: assert property (fire && op_i == OP_AND |=>
		status_o[0] == $past(status_o[0]) && status_o[2] == $past(status_o[2])
		&& status_o[4] == $past(status_o[4]))
		else $error("and changed c ov dc");
	a_bitop_flags: assert property (fire && op_i inside {OP_BIT_CLEAR_OP, OP_BIT_SET_OP,
		OP_BTG, OP_BSWC, OP_BSWZ, OP_TEST_SKIP_IF_CLEAR_OP, OP_BTSS, OP_BRA, OP_BCOND}
		|=> $stable(status_o))
		else $error("flags changed by flagless op");
	a_nop_word: assert property (insn_valid_i && insn_ready_o
		&& insn_word_i[23:16] == 8'h00 |=> !mem_we_o && !pc_load_o
		&& $stable(status_o))
		else $error("second word not a no-op");
	a_stall_bound: assert property (!insn_ready_o |-> ##[1:2] insn_ready_o)
		else $error("stall too long");
	a_read_addr: assert property (!mem_we_o |-> mem_addr_o == file_addr_i)
		else $error("file address mismatch");
	a_file_write: assert property (fire && op_i == OP_ADD && dest_is_file_i
		&& src_sel_i == SRC_FILE |=> mem_we_o)
		else $error("add to file not written");
	c_branch: cover property (fire && op_i == OP_BRA);
	c_skip: cover property (fire && op_i == OP_TEST_SKIP_IF_CLEAR_OP ##1 !insn_ready_o [*2]);
	c_nop: cover property (insn_valid_i && insn_word_i[23:16] == 8'h00);
endmodule
bind exec_datapath exec_datapath_checker chk (
	.clk_i(clk_i), .rstn_i(rstn_i), .insn_valid_i(insn_valid_i),
	.insn_word_i(insn_word_i), .op_i(op_i), .dest_is_file_i(dest_is_file_i),
	.src_sel_i(src_sel_i), .file_addr_i(file_addr_i), .mem_addr_o(mem_addr_o),
	.mem_we_o(mem_we_o), .insn_ready_o(insn_ready_o), .pc_load_o(pc_load_o),
	.pc_target_o(pc_target_o), .flush_o(flush_o), .status_o(status_o)
);
`default_nettype wire

/* File: verif/tb.sv */
// testbench for the execute datapath subset
`timescale 1ns/1ps
`default_nettype none
`include "exec_consts.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
	import exec_pkg::*;
	logic clk_i = 0, rstn_i = 0, insn_valid_i = 0, dest_is_file_i = 1;
	logic sticky_zero_i = 0, next_is_two_word_i = 0;
	logic [23:0] insn_word_i = 24'hAA0000;
	op_t op_i = OP_NOP;
	cond_t cond_i = CC_C;
	logic [3:0] bit_position_field_i = 4'h0;
	logic [4:0] short_immediate_i = 5'h1F;
	src_t src_sel_i = SRC_FILE;
	amode_t dst_mode_i = AM_DIRECT;
	size_t_t size_i = SZ_WORD;
	logic [12:0] file_addr_i = 13'h1FFF;
	logic [22:0] abs_target_i = 23'h000123;
	logic [15:0] mem_rdata_i = 16'h0000, mem_wdata_o;
	logic [12:0] mem_addr_o;
	logic [22:0] pc_target_o;
	logic [4:0] status_o;
	logic mem_we_o, insn_ready_o, pc_load_o, flush_o;
	int err_total = 0, num_checks = 0;
	always #25 clk_i = ~clk_i;
	exec_datapath dut (.clk_i(clk_i), .rstn_i(rstn_i),
		.insn_valid_i(insn_valid_i), .insn_word_i(insn_word_i), .op_i(op_i),
		.cond_i(cond_i), .src_sel_i(src_sel_i), .src_mode_i(AM_DIRECT),
		.dst_mode_i(dst_mode_i), .size_i(size_i), .base_operand_reg_i(4'h0),
		.source_operand_reg_i(4'h1), .destination_operand_reg_i(4'h2),
		.dest_is_file_i(dest_is_file_i), .sticky_zero_i(sticky_zero_i),
		.short_immediate_i(short_immediate_i),
		.medium_immediate_i(10'h3FF),
		.bit_position_field_i(bit_position_field_i), .file_addr_i(file_addr_i),
		.abs_target_i(abs_target_i), .next_is_two_word_i(next_is_two_word_i),
		.mem_addr_o(mem_addr_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
		.mem_rdata_i(mem_rdata_i), .insn_ready_o(insn_ready_o),
		.pc_load_o(pc_load_o), .pc_target_o(pc_target_o), .flush_o(flush_o),
		.status_o(status_o));
	// ----------------------------------------------------------------
	// drivers
	// ----------------------------------------------------------------
	task automatic issue(input op_t o, input logic [15:0] rd);
		@(negedge clk_i);
		op_i = o;
		mem_rdata_i = rd;
		insn_valid_i = 1;
		@(negedge clk_i);
		insn_valid_i = 0;
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_arith();
		`CHK("sr rst", 5'h00, status_o)
		dest_is_file_i = 0;
		issue(OP_ADD, 16'h8000);
		`CHK("acc we", 1'b0, mem_we_o)
		`CHK("acc sr", 5'h08, status_o)
		dest_is_file_i = 1;
		issue(OP_ADD, 16'h8000);
		`CHK("add we", 1'b1, mem_we_o)
		`CHK("add res", 16'h0000, mem_wdata_o)
		`CHK("add sr", 5'h07, status_o)
		issue(OP_AND, 16'hFFFF);
		`CHK("and res", 16'h8000, mem_wdata_o)
		`CHK("and sr", 5'h0D, status_o)
		issue(OP_ADD_WITH_CARRY_OP, 16'h0001);
		`CHK("add_with_carry_op res", 16'h8002, mem_wdata_o)
		`CHK("add_with_carry_op sr", 5'h08, status_o)
		issue(OP_ASR1, 16'h8001);
		`CHK("asr res", 16'hC000, mem_wdata_o)
		`CHK("asr cn", 5'h09, status_o & 5'h09)
	endtask
	task automatic t_branch();
		issue(OP_BRA, 16'h0000);
		`CHK("bra ld", 1'b1, pc_load_o)
		`CHK("bra rdy", 1'b0, insn_ready_o)
		`CHK("bra tgt", 23'h000122, pc_target_o)
		@(negedge clk_i);
		`CHK("bra end", 1'b1, insn_ready_o)
		issue(OP_BRAW, 16'h0000);
		`CHK("braw ld", 1'b1, pc_load_o)
		`CHK("braw fl", 1'b1, flush_o)
		`CHK("braw tgt", 23'h000000, pc_target_o)
		@(negedge clk_i);
		`CHK("braw end", 1'b1, insn_ready_o)
		cond_i = CC_Z;
		issue(OP_BCOND, 16'h0000);
		`CHK("nt ld", 1'b0, pc_load_o)
		`CHK("nt rdy", 1'b1, insn_ready_o)
		cond_i = CC_N;
		issue(OP_BCOND, 16'h0000);
		`CHK("tk ld", 1'b1, pc_load_o)
		@(negedge clk_i);
		`CHK("tk end", 1'b1, insn_ready_o)
	endtask
	task automatic t_bits();
		bit_position_field_i = 4'hF;
		next_is_two_word_i = 1;
		issue(OP_TEST_SKIP_IF_CLEAR_OP, 16'h7FFF);
		`CHK("skip1", 1'b0, insn_ready_o)
		@(negedge clk_i);
		`CHK("skip2", 1'b0, insn_ready_o)
		@(negedge clk_i);
		`CHK("skip end", 1'b1, insn_ready_o)
		issue(OP_TEST_SKIP_IF_CLEAR_OP, 16'h8000);
		`CHK("noskip", 1'b1, insn_ready_o)
		`CHK("skip sr", 5'h09, status_o & 5'h09)
		next_is_two_word_i = 0;
		issue(OP_BTSS, 16'h8000);
		`CHK("skss1", 1'b0, insn_ready_o)
		@(negedge clk_i);
		`CHK("skss end", 1'b1, insn_ready_o)
		issue(OP_BIT_SET_OP, 16'h0000);
		`CHK("bit_set_op", 16'h8000, mem_wdata_o)
		`CHK("bit_set_op adr", 13'h1FFF, mem_addr_o)
		bit_position_field_i = 4'h3;
		issue(OP_BIT_CLEAR_OP, 16'hFFFF);
		`CHK("bit_clear_op", 16'hFFF7, mem_wdata_o)
		bit_position_field_i = 4'h0;
		issue(OP_BTG, 16'h0001);
		`CHK("btg", 16'h0000, mem_wdata_o)
		insn_word_i = 24'h00ABCD;
		issue(OP_ADD, 16'h0001);
		`CHK("nop we", 1'b0, mem_we_o)
		`CHK("nop sr", 5'h09, status_o & 5'h09)
	endtask
	task automatic t_modes();
		insn_word_i = 24'hAA0000;
		issue(OP_BSWC, 16'h0000);
		`CHK("bswc", 16'h0001, mem_wdata_o)
		`CHK("bsw sr", 5'h09, status_o)
		issue(OP_BSWZ, 16'h0000);
		`CHK("bswz", 16'h0000, mem_wdata_o)
		src_sel_i = SRC_SHORT;
		short_immediate_i = 5'h14;
		issue(OP_ASRN, 16'h0000);
		`CHK("asrn res", 16'hFFFF, mem_wdata_o)
		`CHK("asrn sr", 5'h09, status_o)
		src_sel_i = SRC_MED;
		size_i = SZ_BYTE;
		issue(OP_ADD, 16'h0000);
		`CHK("med byte", 16'h00FF, mem_wdata_o)
		`CHK("med b sr", 5'h08, status_o)
		size_i = SZ_WORD;
		dest_is_file_i = 0;
		dst_mode_i = AM_PREINC;
		issue(OP_ADD, 16'h0000);
		`CHK("med word", 16'h03FF, mem_wdata_o)
		`CHK("pre adr", 13'h0002, mem_addr_o)
		`CHK("med w sr", 5'h00, status_o)
		dst_mode_i = AM_DIRECT;
		dest_is_file_i = 1;
		src_sel_i = SRC_FILE;
		sticky_zero_i = 1;
		issue(OP_ADD_WITH_CARRY_OP, 16'h8000);
		`CHK("sticky z", 5'h05, status_o)
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(negedge clk_i);
		rstn_i = 1;
		t_arith();
		t_branch();
		t_bits();
		t_modes();
		test_done();
	end
	initial begin
		#20000;
		err_total++;
		test_done();
	end
endmodule
`default_nettype wire
